/* shared/fsp_regs.svh */
// offsets, field positions, reset values and command codes of the status block
`ifndef FSP_REGS_SVH
`define FSP_REGS_SVH

// ==========================================================
// status word fields
`define FSP_STAT_W 8
`define FSP_BIT_BUSY 0
`define FSP_BIT_LATCH 1
`define FSP_GUARD_LO 2
`define FSP_GUARD_HI 4
`define FSP_BIT_HALF 5
`define FSP_BIT_PAUSE 6
`define FSP_BIT_LOCK 7
`define FSP_STAT_RESET 8'h00

// ==========================================================
// command codes
`define FSP_CMD_LATCH_SET 8'h06
`define FSP_CMD_LATCH_CLR 8'h04
`define FSP_CMD_STAT_RD 8'h05
`define FSP_CMD_STAT_WR 8'h01
`define FSP_CMD_WIPE4K_A 8'h20
`define FSP_CMD_WIPE4K_B 8'hD7
`define FSP_CMD_WIPE64K 8'hD8
`define FSP_CMD_WIPEALL_A 8'h60
`define FSP_CMD_WIPEALL_B 8'hC7
`define FSP_CMD_PAGE 8'h02
`define FSP_CMD_PAGE_LP 8'h0A
`define FSP_CMD_PAUSE 8'hB0
`define FSP_CMD_CONTINUE 8'h30

// ==========================================================
// frame lengths in serial clocks
`define FSP_LEN_CMD 6'h08
`define FSP_LEN_STAT 6'h10
`define FSP_LEN_ADDR 6'h20
`define FSP_LEN_PAGE 6'h28
`define FSP_LEN_MAX 6'h3F

// ==========================================================
// address space
`define FSP_ADDR_W 21
`define FSP_BLK_LSB 16
`define FSP_BLK_TOTAL 6'h20

`endif

/* shared/fsp_pkg.sv */
// types shared by the status and block protect logic
package fsp_pkg;

   // ==========================================================
   // internal write operations handed to the array engine
   typedef enum logic [2:0] {
      OP_WIPE4K,
      OP_WIPE64K,
      OP_WIPE_ALL,
      OP_PAGE,
      OP_PAGE_LP,
      OP_STATUS,
      OP_PAUSE,
      OP_RESUME
   } fsp_op_kind_type;

   typedef struct packed {
      logic valid;
      fsp_op_kind_type kind;
      logic [20:0] addr;
      logic [7:0] data;
   } fsp_op_type;

   // ==========================================================
   // pins from the host side
   typedef struct packed {
      logic sck;
      logic cs_n;
      logic si;
      logic protect_pin_n;
   } fsp_pin_type;

   typedef enum logic {
      LINK_IDLE,
      LINK_FRAME
   } fsp_link_type;

endpackage

/* rtl/fsp_range.sv */
// protected range decoder
`timescale 1ns/100ps
`default_nettype none
`include "fsp_regs.svh"

module fsp_range (
   input wire logic [2:0] guard_size,
   input wire logic protect_half_select,
   input wire logic [20:0] addr,
   output logic hit,
   output logic level_zero
);
   logic [4:0] blk;
   logic [5:0] span;
   logic full;
   logic top_hit;
   logic bot_hit;

   // span counts 64K blocks: 1, 2, 4, 8, 16 for codes 1 to 5
   assign blk = addr[`FSP_ADDR_W-1:`FSP_BLK_LSB];
   assign span = 6'h01 << (guard_size - 3'h1); // [RULE_10]
   assign full = guard_size[2] & guard_size[1]; // [RULE_13]
   assign level_zero = (guard_size == 3'h0); // [RULE_13]
   assign top_hit = ({1'b0, blk} >= (`FSP_BLK_TOTAL - span)); // [RULE_11]
   assign bot_hit = ({1'b0, blk} < span); // [RULE_12]
   assign hit = !level_zero && (full || (protect_half_select ? bot_hit : top_hit)); // [RULE_10]

endmodule // fsp_range
`default_nettype wire

/* rtl/fsp_top.sv */
// status register and block protect logic of the serial flash
// Function
// [RULE_01] Keep an 8-bit readable status word; host rewrites only protection bits.
// [RULE_02] Bits: busy 0, latch 1, guard size 2-4, half select 5, pause 6, lock 7.
// [RULE_03] Busy is 1 while program, erase or status write runs, 0 after.
// [RULE_04] With the write latch clear, refuse erase, program and status write.
// [RULE_05] With the latch set, erase or program only outside the protected range.
// [RULE_06] Latch set by set command, cleared by clear command; host sets first.
// [RULE_07] Latch clears at power-on and when any erase, program or status write completes.
// [RULE_08] A malformed or protected write leaves the latch as it was.
// [RULE_09] Reads never change the latch.
// [RULE_10] Guard size picks the range size, half select picks top or bottom.
// [RULE_11] Top half: codes 1 to 5 protect from 1F0000h..100000h up to 1FFFFFh.
// [RULE_12] Bottom half: codes 1 to 5 protect 000000h up to 00FFFFh..0FFFFFh.
// [RULE_13] Code 0 protects nothing; both upper size bits set protect everything.
// [RULE_14] Full array wipe only when all guard size bits are 0.
// [RULE_15] Pause sets the pause flag; continue or a new erase or program clears it.
// [RULE_16] Lock set and protect pin low: status write ignored entirely.
// [RULE_17] Protect pin high: status word never locked.
// [RULE_18] Non-volatile bits are 0 as delivered.
// [RULE_19] Busy, latch and pause are read-only; written values ignored.
// [RULE_20] Protection bits and lock are kept in non-volatile storage.
// [RULE_21] Host holds protect pin high and sets latch before status write.
// [RULE_22] Status read allowed at any time, even during an internal write.
// [RULE_23] Power-on clears busy and pause, reloads protection bits from storage.
// [RULE_24] Check erase or program address against the range; skip if inside.
`timescale 1ns/100ps
`default_nettype none
`include "fsp_regs.svh"

module fsp_top (
   input wire logic clk_sys,
   input wire logic rst,
   input wire fsp_pkg::fsp_pin_type pins,
   input wire logic [7:0] nv_image,
   input wire logic op_done,
   output logic so_out,
   output logic so_oe,
   output fsp_pkg::fsp_op_type op,
   output logic [7:0] flash_status_word
);
   import fsp_pkg::*;

   // ==========================================================
   // pin synchronisers
   logic [3:0] pin_raw;
   logic [3:0] pin_s1_reg;
   logic [3:0] pin_s2_reg;
   logic [3:0] pin_s3_reg;
   logic [3:0] pin_st_reg;
   logic [3:0] pin_st_next;
   logic [3:0] pin_prev_reg;
   fsp_pin_type pin_now;
   fsp_pin_type pin_old;

   assign pin_raw = pins;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_agree
         assign pin_st_next[gi] = (pin_s2_reg[gi] == pin_s3_reg[gi]) ? pin_s3_reg[gi] : pin_st_reg[gi];
      end
   endgenerate

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pin_s1_reg <= 4'hD;
         pin_s2_reg <= 4'hD;
         pin_s3_reg <= 4'hD;
         pin_st_reg <= 4'hD;
         pin_prev_reg <= 4'hD;
      end else begin
         pin_s1_reg <= pin_raw;
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
         pin_st_reg <= pin_st_next;
         pin_prev_reg <= pin_st_reg;
      end
   end

   assign pin_now = pin_st_reg;
   assign pin_old = pin_prev_reg;

   logic sck_rise;
   logic sck_fall;
   logic cs_fall;
   logic cs_rise;

   assign sck_rise = pin_now.sck && !pin_old.sck;
   assign sck_fall = !pin_now.sck && pin_old.sck;
   assign cs_fall = !pin_now.cs_n && pin_old.cs_n;
   assign cs_rise = pin_now.cs_n && !pin_old.cs_n;

   // ==========================================================
   // frame shifter
   fsp_link_type link_reg;
   logic [5:0] bit_cnt_reg;
   logic [31:0] shift_reg;
   logic [31:0] shift_next;
   logic [7:0] cmd_reg;
   logic [7:0] data_reg;
   logic [20:0] addr_reg;
   logic [2:0] out_idx_reg;
   logic exec_reg;
   logic in_frame;
   logic take_bit;

   assign in_frame = (link_reg == LINK_FRAME);
   assign take_bit = in_frame && sck_rise;
   assign shift_next = {shift_reg[30:0], pin_now.si};

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         link_reg <= LINK_IDLE;
         bit_cnt_reg <= 6'h00;
         shift_reg <= 32'h00000000;
         cmd_reg <= 8'h00;
         data_reg <= 8'h00;
         addr_reg <= 21'h000000;
         exec_reg <= 1'b0;
      end else begin
         exec_reg <= in_frame && cs_rise;
         if (cs_fall) begin
            link_reg <= LINK_FRAME;
            bit_cnt_reg <= 6'h00;
            cmd_reg <= 8'h00;
         end else if (cs_rise) begin
            link_reg <= LINK_IDLE;
         end else if (take_bit) begin
            shift_reg <= shift_next;
            if (bit_cnt_reg != `FSP_LEN_MAX) begin
               bit_cnt_reg <= bit_cnt_reg + 6'h01;
            end
            if (bit_cnt_reg == `FSP_LEN_CMD - 6'h01) begin
               cmd_reg <= shift_next[7:0];
            end
            if (bit_cnt_reg == `FSP_LEN_STAT - 6'h01) begin
               data_reg <= shift_next[7:0];
            end
            if (bit_cnt_reg == `FSP_LEN_ADDR - 6'h01) begin
               addr_reg <= shift_next[`FSP_ADDR_W-1:0];
            end
         end
      end
   end

   // ==========================================================
   // status word and protection decode
   logic busy_reg;
   logic latch_reg;
   logic paused_reg;
   logic [2:0] guard_reg;
   logic half_reg;
   logic lock_reg;
   logic nv_load_reg;
   logic [7:0] stat_word;
   fsp_op_kind_type cur_kind_reg;
   logic range_hit;
   logic level_zero;

   assign stat_word = {lock_reg, paused_reg, half_reg, guard_reg, latch_reg, busy_reg}; // [RULE_02]

   fsp_range u_range (
      .guard_size(guard_reg),
      .protect_half_select(half_reg),
      .addr(addr_reg),
      .hit(range_hit),
      .level_zero(level_zero)
   );

   // ==========================================================
   // command decode at frame end
   logic cmd_len8;
   logic write_ok;
   logic stat_locked;
   logic do_set;
   logic do_clr;
   logic do_status_write_cmd;
   logic do_w4k;
   logic do_w64k;
   logic do_wall;
   logic do_page;
   logic do_pause;
   logic do_cont;
   logic do_array;
   logic do_start;
   logic is_status_read_cmd;
   logic cur_array;

   assign cmd_len8 = exec_reg && (bit_cnt_reg == `FSP_LEN_CMD);
   assign write_ok = latch_reg && !busy_reg; // [RULE_04]
   assign stat_locked = lock_reg && !pin_now.protect_pin_n; // [RULE_17]
   assign do_set = cmd_len8 && (cmd_reg == `FSP_CMD_LATCH_SET); // [RULE_06]
   assign do_clr = cmd_len8 && (cmd_reg == `FSP_CMD_LATCH_CLR); // [RULE_06]
   assign do_status_write_cmd = exec_reg && (cmd_reg == `FSP_CMD_STAT_WR) && (bit_cnt_reg == `FSP_LEN_STAT)
      && write_ok && !stat_locked; // [RULE_16] [RULE_21]
   assign do_w4k = exec_reg && ((cmd_reg == `FSP_CMD_WIPE4K_A) || (cmd_reg == `FSP_CMD_WIPE4K_B))
      && (bit_cnt_reg == `FSP_LEN_ADDR) && write_ok && !range_hit; // [RULE_05] [RULE_24]
   assign do_w64k = exec_reg && (cmd_reg == `FSP_CMD_WIPE64K)
      && (bit_cnt_reg == `FSP_LEN_ADDR) && write_ok && !range_hit; // [RULE_05] [RULE_24]
   assign do_wall = cmd_len8 && ((cmd_reg == `FSP_CMD_WIPEALL_A) || (cmd_reg == `FSP_CMD_WIPEALL_B))
      && write_ok && level_zero; // [RULE_14]
   assign do_page = exec_reg && ((cmd_reg == `FSP_CMD_PAGE) || (cmd_reg == `FSP_CMD_PAGE_LP))
      && (bit_cnt_reg >= `FSP_LEN_PAGE) && write_ok && !range_hit; // [RULE_05] [RULE_24]
   assign cur_array = (cur_kind_reg != OP_STATUS);
   assign do_pause = cmd_len8 && (cmd_reg == `FSP_CMD_PAUSE) && busy_reg && cur_array; // [RULE_15]
   assign do_cont = cmd_len8 && (cmd_reg == `FSP_CMD_CONTINUE) && paused_reg; // [RULE_15]
   assign do_array = do_w4k || do_w64k || do_wall || do_page;
   assign do_start = do_array || do_status_write_cmd;
   assign is_status_read_cmd = exec_reg && (cmd_reg == `FSP_CMD_STAT_RD);

   fsp_op_kind_type kind_sel;

   assign kind_sel = do_w4k ? OP_WIPE4K :
      do_w64k ? OP_WIPE64K :
      do_wall ? OP_WIPE_ALL :
      do_page ? ((cmd_reg == `FSP_CMD_PAGE_LP) ? OP_PAGE_LP : OP_PAGE) :
      do_status_write_cmd ? OP_STATUS :
      do_pause ? OP_PAUSE : OP_RESUME;

   // ==========================================================
   // status flags
   logic busy_next;
   logic latch_next;
   logic paused_next;

   assign busy_next = (do_start || do_cont) ? 1'b1 :
      (do_pause || op_done) ? 1'b0 : busy_reg; // [RULE_03]
   // a set arriving with a completion wins
   assign latch_next = do_set ? 1'b1 :
      (do_clr || (op_done && busy_reg)) ? 1'b0 : latch_reg; // [RULE_06] [RULE_07] [RULE_08] [RULE_09]
   assign paused_next = do_pause ? 1'b1 :
      (do_cont || do_array) ? 1'b0 : paused_reg; // [RULE_15]

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         busy_reg <= 1'b0; // [RULE_23]
         latch_reg <= 1'b0; // [RULE_07]
         paused_reg <= 1'b0; // [RULE_23]
         guard_reg <= 3'(`FSP_STAT_RESET >> `FSP_GUARD_LO); // [RULE_18]
         half_reg <= 1'b0;
         lock_reg <= 1'b0;
         nv_load_reg <= 1'b1;
         cur_kind_reg <= OP_STATUS;
      end else begin
         busy_reg <= busy_next;
         latch_reg <= latch_next;
         paused_reg <= paused_next;
         nv_load_reg <= 1'b0;
         if (nv_load_reg) begin
            guard_reg <= nv_image[`FSP_GUARD_HI:`FSP_GUARD_LO]; // [RULE_23] [RULE_20]
            half_reg <= nv_image[`FSP_BIT_HALF];
            lock_reg <= nv_image[`FSP_BIT_LOCK];
         end else if (do_status_write_cmd) begin
            guard_reg <= data_reg[`FSP_GUARD_HI:`FSP_GUARD_LO]; // [RULE_01] [RULE_19]
            half_reg <= data_reg[`FSP_BIT_HALF];
            lock_reg <= data_reg[`FSP_BIT_LOCK];
         end
         if (do_start) begin
            cur_kind_reg <= kind_sel;
         end
      end
   end

   // ==========================================================
   // outputs
   logic status_read_cmd_phase;

   assign status_read_cmd_phase = in_frame && (cmd_reg == `FSP_CMD_STAT_RD) && (bit_cnt_reg >= `FSP_LEN_CMD);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         so_out <= 1'b0;
         so_oe <= 1'b0;
         out_idx_reg <= 3'h7;
         op <= '0;
         flash_status_word <= `FSP_STAT_RESET;
      end else begin
         flash_status_word <= stat_word; // [RULE_01]
         op.valid <= do_start || do_pause || do_cont;
         op.kind <= kind_sel;
         op.addr <= addr_reg;
         op.data <= data_reg; // [RULE_20]
         if (cs_fall || cs_rise) begin
            so_oe <= 1'b0;
            out_idx_reg <= 3'h7;
         end else if (sck_fall && status_read_cmd_phase) begin
            so_out <= stat_word[out_idx_reg]; // [RULE_22]
            so_oe <= 1'b1;
            out_idx_reg <= out_idx_reg - 3'h1;
         end
      end
   end

   // ==========================================================
   // checks
   sequence seq_start;
      do_start ##1 (busy_reg && op.valid);
   endsequence

   sequence seq_pause;
      do_pause ##1 (paused_reg && !busy_reg && op.valid && (op.kind == OP_PAUSE));
   endsequence

   AST_BUSY_ON_START: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_03]
      do_start |-> seq_start) else $error("busy not raised on write start");
   AST_BUSY_DONE: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_03]
      (busy_reg && op_done && !do_start && !do_cont) |=> !busy_reg) else $error("busy stuck after done");
   AST_LATCH_CLR_DONE: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_07]
      (busy_reg && op_done && !do_set) |=> !latch_reg) else $error("latch kept after write done");
   AST_NO_WRITE_UNLATCHED: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_04]
      (op.valid && (op.kind inside {OP_WIPE4K, OP_WIPE64K, OP_WIPE_ALL, OP_PAGE, OP_PAGE_LP, OP_STATUS}))
      |-> $past(latch_reg)) else $error("write started without latch");
   AST_PROT_SKIP: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_24]
      (exec_reg && (cmd_reg == `FSP_CMD_WIPE64K) && range_hit && !op_done) |=> (!op.valid && $stable(latch_reg)))
      else $error("protected erase accepted");
   AST_WIPE_ALL_LEVEL: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_14]
      (op.valid && (op.kind == OP_WIPE_ALL)) |-> ($past(guard_reg) == 3'h0)) else $error("wipe with guard set");
   AST_PAUSE_SET: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_15]
      do_pause |-> seq_pause) else $error("pause flag not set");
   AST_STATUS_WRITE_CMD_LOCKED: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_16]
      (exec_reg && (cmd_reg == `FSP_CMD_STAT_WR) && lock_reg && !pin_now.protect_pin_n && !nv_load_reg)
      |=> ($stable(guard_reg) && $stable(half_reg) && $stable(lock_reg) && !op.valid))
      else $error("locked status write took effect");
   AST_READ_KEEPS_LATCH: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_09]
      (is_status_read_cmd && !op_done) |=> $stable(latch_reg)) else $error("read changed latch");
   AST_RANGE_FULL: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_13]
      (exec_reg && (cmd_reg == `FSP_CMD_WIPE64K) && guard_reg[2] && guard_reg[1]) |=> !op.valid)
      else $error("full guard missed address");
   AST_STATUS_READ_CMD_DRIVE: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_22]
      (sck_fall && status_read_cmd_phase && !cs_rise) |=> so_oe ##0 (so_out == $past(stat_word[out_idx_reg])))
      else $error("status bit not driven");

endmodule // fsp_top
`default_nettype wire

/* tb/fsp_host_model.sv */
// spi host model that drives the status block pins
`timescale 1ns/100ps
`default_nettype none

module fsp_host_model (
   input wire logic clk_sys,
   input wire logic so_out,
   output var fsp_pkg::fsp_pin_type pins
);
   import fsp_pkg::*;

   initial begin
      pins = '{sck: 1'h0, cs_n: 1'h1, si: 1'h0, protect_pin_n: 1'h1};
   end

   // ==========================================================
   // mode 0 frame, msb first; bits after the 8th clock are read back
   task automatic xfer(input logic [39:0] d, input int n, input logic pin_n, output logic [7:0] rd);
      int i;
      rd = 8'h00;
      pins.protect_pin_n <= pin_n;
      repeat (8) @(posedge clk_sys);
      pins.cs_n <= 1'h0;
      repeat (4) @(posedge clk_sys);
      for (i = 0; i < n; i++) begin
         pins.sck <= 1'h0;
         pins.si <= d[39-i];
         repeat (4) @(posedge clk_sys);
         pins.sck <= 1'h1;
         repeat (4) @(posedge clk_sys);
         if (i >= 8) begin
            rd = {rd[6:0], so_out};
         end
      end
      pins.sck <= 1'h0;
      repeat (4) @(posedge clk_sys);
      pins.cs_n <= 1'h1;
      // released data line shows no stale bit
      pins.si <= ~pins.si;
      repeat (12) @(posedge clk_sys);
   endtask
endmodule // fsp_host_model

`default_nettype wire

/* tb/flash_status_and_block_protect_tb_top.sv */
// self-checking bench for the status word and block protect logic
`timescale 1ns/100ps
`default_nettype none
`include "fsp_regs.svh"

module flash_status_and_block_protect_tb_top;
   import fsp_pkg::*;

   logic clk_sys = 1'h0;
   logic rst = 1'h1;
   logic [7:0] nv_image = 8'h00;
   logic op_done = 1'h0;
   logic so_out;
   logic so_oe;
   logic [7:0] flash_status_word;
   fsp_pin_type pins;
   fsp_op_type op;
   int num_errors = 0;
   int comparisons = 0;
   int op_cnt = 0;
   int oe_cnt = 0;
   int cycles = 0;
   int seed = 88;
   fsp_op_kind_type last_kind = OP_WIPE4K;
   logic [20:0] last_addr = 21'h000000;
   logic [7:0] last_data = 8'h00;
   logic [7:0] exp_st;
   logic [7:0] rd;
   logic [7:0] ro;
   logic [20:0] addr;
   logic p;
   int g;
   int h;
   int k;
   logic [7:0] ecode [5] = '{`FSP_CMD_WIPE4K_A, `FSP_CMD_WIPE4K_B, `FSP_CMD_WIPE64K, `FSP_CMD_PAGE, `FSP_CMD_PAGE_LP};
   fsp_op_kind_type ekind [5] = '{OP_WIPE4K, OP_WIPE4K, OP_WIPE64K, OP_PAGE, OP_PAGE_LP};
   int elen [5] = '{32, 32, 32, 40, 40};

   always #4 clk_sys = ~clk_sys;

   fsp_top u_fsp_top (
      .clk_sys(clk_sys),
      .rst(rst),
      .pins(pins),
      .nv_image(nv_image),
      .op_done(op_done),
      .so_out(so_out),
      .so_oe(so_oe),
      .op(op),
      .flash_status_word(flash_status_word)
   );

   fsp_host_model u_fsp_host_model (
      .clk_sys(clk_sys),
      .so_out(so_out),
      .pins(pins)
   );

   // ==========================================================
   // op monitor and timeout
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (op.valid === 1'h1) begin
         op_cnt <= op_cnt + 1;
         last_kind <= op.kind;
         last_addr <= op.addr;
         last_data <= op.data;
      end
      if (so_oe === 1'h1) begin
         oe_cnt <= oe_cnt + 1;
      end
      if (cycles == 60000) begin
         num_errors = num_errors + 1;
         $display("ERROR %0t: run did not finish in time", $time);
         stop_test();
      end
   end

   // ==========================================================
   // compares and helpers
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t: byte %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_op(input int dn, input bit want, input fsp_op_kind_type kd);
      comparisons++;
      if (dn != int'(want) || (want && last_kind !== kd)) begin
         num_errors++;
         $display("ERROR %0t: %0d ops kind %0d, expected %0d kind %0d", $time, dn, last_kind, want, kd);
      end
   endtask

   task automatic chk_addr(input logic [20:0] got, input logic [20:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t: address %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic cmd(input logic [39:0] d, input int n, input bit want, input fsp_op_kind_type kd,
                      input logic pin_n = 1'h1);
      int c0;
      c0 = op_cnt;
      u_fsp_host_model.xfer(d, n, pin_n, rd);
      chk_op(op_cnt - c0, want, kd);
   endtask

   task automatic latch_on();
      cmd({`FSP_CMD_LATCH_SET, 32'h00000000}, 8, 1'h0, OP_PAGE);
   endtask

   task automatic done();
      @(posedge clk_sys);
      op_done <= 1'h1;
      @(posedge clk_sys);
      op_done <= 1'h0;
      repeat (4) @(posedge clk_sys);
   endtask

   // protected test of an address from guard size and half select
   function automatic logic prot(input logic [2:0] gs, input logic hs, input logic [20:0] a);
      int nb;
      if (gs == 3'h0) return 1'h0;
      if (gs[2] && gs[1]) return 1'h1;
      nb = 1 << (gs - 1);
      return hs ? (int'(a[20:16]) < nb) : (int'(a[20:16]) >= 32 - nb);
   endfunction

   task automatic stop_test();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end
      else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ==========================================================
   // main sequence
   initial begin
      repeat (5) @(posedge clk_sys);
      rst <= 1'h0;
      repeat (4) @(posedge clk_sys);
      chk_byte(flash_status_word, 8'h00);
      cmd({`FSP_CMD_STAT_WR, 8'h9C, 24'h000000}, 16, 1'h0, OP_STATUS);
      chk_byte(flash_status_word, 8'h00);
      latch_on();
      chk_byte(flash_status_word, 8'h02);
      k = oe_cnt;
      cmd({`FSP_CMD_STAT_RD, 32'h00000000}, 16, 1'h0, OP_PAGE);
      chk_byte(rd, 8'h02);
      chk_byte({6'h00, oe_cnt > k, so_oe}, 8'h02);
      chk_byte(flash_status_word, 8'h02);
      cmd({`FSP_CMD_LATCH_CLR, 32'h00000000}, 8, 1'h0, OP_PAGE);
      chk_byte(flash_status_word, 8'h00);
      for (g = 0; g < 8; g++) begin
         for (h = 0; h < 2; h++) begin
            latch_on();
            ro = 8'($random(seed));
            cmd({`FSP_CMD_STAT_WR, 1'h0, ro[6], h[0], g[2:0], ro[1:0], 24'h000000}, 16, 1'h1, OP_STATUS);
            chk_byte(flash_status_word, {2'h0, h[0], g[2:0], 2'h3});
            chk_byte(last_data & 8'hBC, {2'h0, h[0], g[2:0], 2'h0});
            done();
            exp_st = {2'h0, h[0], g[2:0], 2'h0};
            chk_byte(flash_status_word, exp_st);
            for (k = 0; k < 5; k++) begin
               addr = 21'($random(seed));
               p = prot(g[2:0], h[0], addr);
               latch_on();
               cmd({ecode[k], 3'h0, addr, 8'h00}, elen[k], !p, ekind[k]);
               chk_byte(flash_status_word, exp_st | (p ? 8'h02 : 8'h03));
               if (!p) begin
                  chk_addr(last_addr, addr);
                  done();
                  chk_byte(flash_status_word, exp_st);
               end
            end
            latch_on();
            cmd({(h[0] ? `FSP_CMD_WIPEALL_B : `FSP_CMD_WIPEALL_A), 32'h00000000}, 8, g == 0, OP_WIPE_ALL);
            if (g == 0) begin
               done();
            end
         end
      end
      latch_on();
      cmd({`FSP_CMD_STAT_WR, 8'h80, 24'h000000}, 16, 1'h1, OP_STATUS);
      done();
      latch_on();
      cmd({`FSP_CMD_STAT_WR, 8'h04, 24'h000000}, 16, 1'h0, OP_STATUS, 1'h0);
      chk_byte(flash_status_word, 8'h82);
      cmd({`FSP_CMD_STAT_WR, 8'h00, 24'h000000}, 16, 1'h1, OP_STATUS);
      done();
      chk_byte(flash_status_word, 8'h00);
      latch_on();
      cmd({`FSP_CMD_WIPE64K, 32'h00000000}, 32, 1'h1, OP_WIPE64K);
      cmd({`FSP_CMD_PAUSE, 32'h00000000}, 8, 1'h1, OP_PAUSE);
      chk_byte(flash_status_word, 8'h42);
      cmd({`FSP_CMD_STAT_RD, 32'h00000000}, 16, 1'h0, OP_PAGE);
      chk_byte(rd, 8'h42);
      cmd({`FSP_CMD_CONTINUE, 32'h00000000}, 8, 1'h1, OP_RESUME);
      chk_byte(flash_status_word, 8'h03);
      cmd({`FSP_CMD_PAUSE, 32'h00000000}, 8, 1'h1, OP_PAUSE);
      chk_byte(flash_status_word, 8'h42);
      cmd({`FSP_CMD_WIPE4K_A, 32'h00000000}, 32, 1'h1, OP_WIPE4K);
      chk_byte(flash_status_word, 8'h03);
      done();
      chk_byte(flash_status_word, 8'h00);
      nv_image <= 8'($random(seed));
      rst <= 1'h1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'h0;
      repeat (4) @(posedge clk_sys);
      chk_byte(flash_status_word, nv_image & 8'hBC);
      stop_test();
   end
endmodule // flash_status_and_block_protect_tb_top

`default_nettype wire
